/* rtl/ccm_ctrl_pkg.sv */
// shared offsets, field positions and reset values for the cipher control slice
package ccm_ctrl_pkg;
    localparam int ADDR_W = 12;
    localparam logic [ADDR_W-1:0] OFF_LINK_CFG = 12'h200;
    localparam logic [ADDR_W-1:0] OFF_IRQ_SET = 12'h304;
    localparam logic [ADDR_W-1:0] OFF_IRQ_CLR = 12'h308;
    localparam logic [ADDR_W-1:0] OFF_MIC = 12'h400;
    localparam logic [ADDR_W-1:0] OFF_ENABLE = 12'h500;
    // unmapped word, answered with an error response
    localparam logic [ADDR_W-1:0] OFF_CTRL_RSVD = 12'h000;
    localparam int BIT_KS = 0;
    localparam int BIT_CIPHER_RUN_TASK = 1;
    localparam int BIT_ERR = 2;
    localparam int N_EVT = 3;
    localparam int ENABLE_W = 2;
    localparam logic [1:0] ENABLE_OFF = 2'h0;
    localparam logic [1:0] ENABLE_ON = 2'h2;
    localparam logic [1:0] ENABLE_RST = 2'h0;
    localparam logic LINK_RST = 1'b0;
    localparam logic [N_EVT-1:0] IRQ_EN_RST = 3'h0;
    localparam logic MIC_RST = 1'b0;
    typedef enum logic [1:0] {
        RUN_IDLE,
        RUN_BUSY
    } run_state_t;
endpackage

/* rtl/ccm_event_latch.sv */
// sticky event flags with set-over-clear priority
`timescale 1ns/1ps
module ccm_event_latch #(
    parameter int WIDTH = 3
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // event pulses and clears
    input wire logic [WIDTH-1:0] set_i,
    input wire logic [WIDTH-1:0] clr_i,
    // held flags
    output logic [WIDTH-1:0] flag_o
);
    logic [WIDTH-1:0] flag_reg;
    logic [WIDTH-1:0] flag_next;

    // set wins so an event in the clear cycle is never lost
    always_comb begin
        flag_next = (flag_reg & ~clr_i) | set_i;
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            flag_reg <= '0;
        end else begin
            flag_reg <= flag_next;
        end
    end

    assign flag_o = flag_reg;
endmodule // ccm_event_latch

/* rtl/ccm_ctrl.sv */
// control and status registers of the packet cipher unit
`timescale 1ns/1ps
module ccm_ctrl
    import ccm_ctrl_pkg::*;
(
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [ccm_ctrl_pkg::ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // events from the cipher core
    input wire logic keystream_done_event_i,
    input wire logic cipher_done_event_i,
    input wire logic error_event_i,
    input wire logic mic_valid_i,
    input wire logic mic_pass_i,
    input wire logic cipher_run_task_i,
    input wire logic [ccm_ctrl_pkg::N_EVT-1:0] event_clear_i,
    // outputs to the cipher core
    output logic cipher_start_o,
    output logic cipher_busy_o,
    output logic unit_on_o,
    output logic irq_o
);
    import ccm_ctrl_pkg::*;

    logic link_reg, link_next;
    logic [N_EVT-1:0] irq_en_reg, irq_en_next;
    logic [ENABLE_W-1:0] enable_reg, enable_next;
    logic mic_reg, mic_next;
    logic [31:0] prdata_reg, prdata_next;
    logic pready_reg, pready_next;
    logic pslverr_reg, pslverr_next;
    logic start_reg, start_next;
    logic irq_reg, irq_next;
    run_state_t run_reg, run_next;
    logic [N_EVT-1:0] evt_flag;
    logic [N_EVT-1:0] evt_set;
    logic acc, wr, rd;
    logic unit_on;
    logic busy_reg, busy_next;
    logic unit_on_reg, unit_on_next;

    // address is mapped when it hits one of the five words
    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        return (a == OFF_LINK_CFG) || (a == OFF_IRQ_SET) ||
            (a == OFF_IRQ_CLR) || (a == OFF_MIC) || (a == OFF_ENABLE);
    endfunction

    // access phase; ready follows one cycle later
    assign acc = psel_i && penable_i && !pready_reg;
    assign wr = acc && pwrite_i;
    assign rd = acc && !pwrite_i;
    assign unit_on = (enable_reg == ENABLE_ON);

    assign evt_set = {error_event_i, cipher_done_event_i,
        keystream_done_event_i};

    ccm_event_latch #(
        .WIDTH(N_EVT)
    ) u_evt (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .set_i(evt_set),
        .clr_i(event_clear_i),
        .flag_o(evt_flag)
    );

    // register file next values
    always_comb begin
        link_next = link_reg;
        irq_en_next = irq_en_reg;
        enable_next = enable_reg;
        mic_next = mic_reg;
        if (wr && paddr_i == OFF_LINK_CFG) begin
            link_next = pwdata_i[0];
        end
        if (wr && paddr_i == OFF_IRQ_SET) begin
            // shared enable bits, zeros ignored
            irq_en_next[BIT_KS] = irq_en_reg[BIT_KS] | pwdata_i[BIT_KS];
            irq_en_next[BIT_CIPHER_RUN_TASK] = irq_en_reg[BIT_CIPHER_RUN_TASK] |
                pwdata_i[BIT_CIPHER_RUN_TASK];
            irq_en_next[BIT_ERR] = irq_en_reg[BIT_ERR] |
                pwdata_i[BIT_ERR];
        end
        if (wr && paddr_i == OFF_IRQ_CLR) begin
            irq_en_next = irq_en_reg & ~pwdata_i[N_EVT-1:0];
        end
        if (wr && paddr_i == OFF_ENABLE) begin
            enable_next = pwdata_i[ENABLE_W-1:0];
        end
        // flopped so the pin leaves a register
        unit_on_next = (enable_next == ENABLE_ON);
        // result kept until the next decryption reports
        if (mic_valid_i) begin
            mic_next = mic_pass_i;
        end
    end

    // apb answer: zero-wait beyond the one ready cycle
    always_comb begin
        prdata_next = 32'h0;
        pready_next = acc;
        pslverr_next = acc && !is_mapped(paddr_i);
        if (rd) begin
            case (paddr_i)
                OFF_LINK_CFG: prdata_next[0] = link_reg;
                OFF_IRQ_SET: prdata_next[N_EVT-1:0] = irq_en_reg;
                OFF_IRQ_CLR: prdata_next[N_EVT-1:0] = irq_en_reg;
                OFF_MIC: prdata_next[0] = mic_reg;
                OFF_ENABLE: prdata_next[ENABLE_W-1:0] = enable_reg;
                default: prdata_next = 32'h0;
            endcase
        end
    end

    // cipher task: start pulse, busy until done or the unit is switched off
    always_comb begin
        start_next = 1'b0;
        run_next = run_reg;
        case (run_reg)
            RUN_IDLE: begin
                if (unit_on && (cipher_run_task_i ||
                    (link_reg && keystream_done_event_i))) begin
                    start_next = 1'b1;
                    run_next = RUN_BUSY;
                end
            end
            RUN_BUSY: begin
                if (cipher_done_event_i || !unit_on) begin
                    run_next = RUN_IDLE;
                end
            end
            default: run_next = RUN_IDLE;
        endcase
        busy_next = (run_next == RUN_BUSY);
    end

    // interrupt level from pending and enabled events
    always_comb begin
        irq_next = |(evt_flag & irq_en_reg);
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            link_reg <= LINK_RST;
            irq_en_reg <= IRQ_EN_RST;
            enable_reg <= ENABLE_RST;
            mic_reg <= MIC_RST;
            prdata_reg <= 32'h0;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            start_reg <= 1'b0;
            irq_reg <= 1'b0;
            run_reg <= RUN_IDLE;
            busy_reg <= 1'b0;
            unit_on_reg <= 1'b0;
        end else begin
            link_reg <= link_next;
            irq_en_reg <= irq_en_next;
            enable_reg <= enable_next;
            mic_reg <= mic_next;
            prdata_reg <= prdata_next;
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
            start_reg <= start_next;
            irq_reg <= irq_next;
            run_reg <= run_next;
            busy_reg <= busy_next;
            unit_on_reg <= unit_on_next;
        end
    end

    assign prdata_o = prdata_reg;
    assign pready_o = pready_reg;
    assign pslverr_o = pslverr_reg;
    assign cipher_start_o = start_reg;
    assign cipher_busy_o = busy_reg;
    assign unit_on_o = unit_on_reg;
    assign irq_o = irq_reg;

    // checks next to the logic; each one names its clock and reset
    sequence s_link_trig;
        run_reg == RUN_IDLE && unit_on && link_reg && keystream_done_event_i;
    endsequence

    // a direct trigger seen while idle with the unit on
    sequence s_task_trig;
        run_reg == RUN_IDLE && unit_on && cipher_run_task_i;
    endsequence

    // the answer to a trigger: one start pulse with busy raised
    sequence s_start_seen;
        start_reg && cipher_busy_o;
    endsequence

    // busy side of a run that has just finished
    sequence s_run_done;
        cipher_busy_o && cipher_done_event_i;
    endsequence

    a_link_starts: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        s_link_trig |=> s_start_seen)
        else $error("link did not start cipher");

    // with the link off a keystream event alone must not start a run
    a_no_link_start: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (run_reg == RUN_IDLE && !cipher_run_task_i && !link_reg) |=>
        !start_reg)
        else $error("start without trigger");

    a_task_starts: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        s_task_trig |=> s_start_seen)
        else $error("task trigger did not start cipher");

    // one cycle of start only, so the core never sees a double trigger
    a_start_pulse: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        start_reg |=> !start_reg)
        else $error("start pulse too long");

    a_task_stops: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        s_run_done |=> !cipher_busy_o)
        else $error("cipher task did not stop");

    // set register: a one enables, a zero leaves the bit alone
    a_set_enables: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (wr && paddr_i == OFF_IRQ_SET && pwdata_i[BIT_KS]) |=>
        irq_en_reg[BIT_KS])
        else $error("set did not enable keystream irq");
    a_set_cipher_run_task: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (wr && paddr_i == OFF_IRQ_SET && pwdata_i[BIT_CIPHER_RUN_TASK]) |=>
        irq_en_reg[BIT_CIPHER_RUN_TASK])
        else $error("set did not enable cipher irq");
    a_set_err: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (wr && paddr_i == OFF_IRQ_SET && pwdata_i[BIT_ERR]) |=>
        irq_en_reg[BIT_ERR])
        else $error("set did not enable error irq");

    // zeros written to the set register never drop an enable
    a_set_keeps: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (wr && paddr_i == OFF_IRQ_SET) |=>
        ((irq_en_reg & $past(irq_en_reg)) == $past(irq_en_reg)))
        else $error("set register dropped an enable");

    // clear register: a one disables that event's enable
    a_clr_ks: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (wr && paddr_i == OFF_IRQ_CLR && pwdata_i[BIT_KS]) |=>
        !irq_en_reg[BIT_KS])
        else $error("clear did not disable keystream irq");
    a_clr_cipher_run_task: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (wr && paddr_i == OFF_IRQ_CLR && pwdata_i[BIT_CIPHER_RUN_TASK]) |=>
        !irq_en_reg[BIT_CIPHER_RUN_TASK])
        else $error("clear did not disable cipher irq");
    a_clr_err: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (wr && paddr_i == OFF_IRQ_CLR && pwdata_i[BIT_ERR]) |=>
        !irq_en_reg[BIT_ERR])
        else $error("clear did not disable error irq");

    // both addresses read back the one shared set of enables
    a_shared_read: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (rd && (paddr_i == OFF_IRQ_SET || paddr_i == OFF_IRQ_CLR)) |=>
        (prdata_o[N_EVT-1:0] == $past(irq_en_reg) && pready_o))
        else $error("enable readback mismatch");

    // result register follows each reported decryption
    a_mic_holds: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        mic_valid_i |=> (mic_reg == $past(mic_pass_i)))
        else $error("integrity result not captured");

    a_enable_on: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (wr && paddr_i == OFF_ENABLE && pwdata_i[1:0] == ENABLE_ON) |=>
        unit_on_o)
        else $error("unit not enabled");

    a_enable_off: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (wr && paddr_i == OFF_ENABLE && pwdata_i[1:0] == ENABLE_OFF) |=>
        !unit_on_o)
        else $error("unit not disabled");

    // irq trails the pending-and-enabled set by one cycle
    a_irq_level: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (|(evt_flag & irq_en_reg)) |=> irq_o)
        else $error("irq missing for enabled event");

    a_irq_quiet: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        !(|(evt_flag & irq_en_reg)) |=> !irq_o)
        else $error("irq without enabled event");
endmodule // ccm_ctrl

/* tb/tb.sv */
// self-checking bench for the cipher control register slice
`timescale 1ns/1ps
module tb;
    import ccm_ctrl_pkg::*;
    logic ref_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata;
    logic pready, pslverr, start, busy, unit_on, irq;
    logic [7:0] drv = 8'h00; // [2:0] events [5:3] clears [6] mic [7] run
    logic mic_pass = 1'b0;
    int miscompares = 0;
    int n_compared = 0;
    int n_start = 0;
    always #50 ref_clk_i = ~ref_clk_i;
    // start pulses counted mid-cycle, where they have settled
    always @(negedge ref_clk_i) if (start === 1'b1) n_start++;
    ccm_ctrl u_dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr),
        .keystream_done_event_i(drv[0]), .cipher_done_event_i(drv[1]),
        .error_event_i(drv[2]), .event_clear_i(drv[5:3]),
        .mic_valid_i(drv[6]), .mic_pass_i(mic_pass),
        .cipher_run_task_i(drv[7]), .cipher_start_o(start),
        .cipher_busy_o(busy), .unit_on_o(unit_on), .irq_o(irq));
    task automatic report_and_stop();
        $display("compared %0d, miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, g);
        n_compared++;
        if (g !== e) begin
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
            miscompares++;
        end
    endtask
    // one apb transfer; the request stands until pready is seen high
    task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
        input logic [31:0] wd, output logic [31:0] rd, output logic er);
        int n;
        @(posedge ref_clk_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge ref_clk_i);
        penable <= 1'b1;
        n = 0;
        // answer taken at the very edge that samples ready high
        do begin
            @(posedge ref_clk_i);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            miscompares++;
            report_and_stop();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rdc(input string nm, input logic [ADDR_W-1:0] a,
        input logic [31:0] x, input logic xe);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(nm, x, r);
        chk("pslverr", {31'h0, xe}, {31'h0, e});
    endtask
    task automatic pulse(input logic [7:0] v);
        @(posedge ref_clk_i);
        drv <= v;
        @(posedge ref_clk_i);
        drv <= 8'h00;
    endtask
    task automatic t_reset();
        rdc("link", OFF_LINK_CFG, 32'h0, 1'b0);
        rdc("irq set", OFF_IRQ_SET, 32'h0, 1'b0);
        rdc("irq clr", OFF_IRQ_CLR, 32'h0, 1'b0);
        rdc("mic", OFF_MIC, 32'h0, 1'b0);
        rdc("enable", OFF_ENABLE, 32'h0, 1'b0);
        rdc("unmapped", OFF_CTRL_RSVD, 32'h0, 1'b1);
        chk("unit on", 32'h0, {31'h0, unit_on});
        chk("busy", 32'h0, {31'h0, busy});
        chk("irq", 32'h0, {31'h0, irq});
        $display("test reset values done");
    endtask
    task automatic t_irq_en();
        logic [31:0] m;
        m = 32'h0;
        for (int i = 0; i < N_EVT; i++) begin
            wr(OFF_IRQ_SET, 32'h1 << i);
            m = m | (32'h1 << i);
            wr(OFF_IRQ_SET, 32'h0);
            rdc("set view", OFF_IRQ_SET, m, 1'b0);
            rdc("clr view", OFF_IRQ_CLR, m, 1'b0);
        end
        for (int i = 0; i < N_EVT; i++) begin
            wr(OFF_IRQ_CLR, 32'h1 << i);
            m = m & ~(32'h1 << i);
            wr(OFF_IRQ_CLR, 32'h0);
            rdc("set view", OFF_IRQ_SET, m, 1'b0);
            rdc("clr view", OFF_IRQ_CLR, m, 1'b0);
        end
        $display("test irq enables done");
    endtask
    task automatic irq_is(input logic e);
        repeat (3) @(negedge ref_clk_i);
        chk("irq", {31'h0, e}, {31'h0, irq});
    endtask
    task automatic t_irq();
        wr(OFF_IRQ_SET, 32'h1);
        pulse(8'h04); // error flag pending but masked
        irq_is(1'b0);
        pulse(8'h01);
        irq_is(1'b1);
        pulse(8'h08); // clear keystream flag only
        irq_is(1'b0);
        pulse(8'h02);
        wr(OFF_IRQ_SET, 32'h2);
        irq_is(1'b1);
        wr(OFF_IRQ_CLR, 32'h3);
        irq_is(1'b0);
        wr(OFF_IRQ_SET, 32'h1);
        pulse(8'h09); // event and clear together: the event wins
        irq_is(1'b1);
        wr(OFF_IRQ_CLR, 32'h1);
        pulse(8'h38);
        $display("test irq output done");
    endtask
    task automatic t_task();
        int s;
        s = n_start;
        pulse(8'h80); // refused while the unit is off
        repeat (2) @(negedge ref_clk_i);
        chk("start off", s, n_start);
        wr(OFF_ENABLE, {30'h0, ENABLE_ON});
        rdc("enable", OFF_ENABLE, 32'h2, 1'b0);
        chk("unit on", 32'h1, {31'h0, unit_on});
        pulse(8'h80);
        repeat (2) @(negedge ref_clk_i);
        chk("start", s + 1, n_start);
        chk("busy", 32'h1, {31'h0, busy});
        pulse(8'h80); // refused while busy
        pulse(8'h02);
        repeat (2) @(negedge ref_clk_i);
        chk("start busy", s + 1, n_start);
        chk("busy done", 32'h0, {31'h0, busy});
        pulse(8'h01); // link off: no chaining
        repeat (2) @(negedge ref_clk_i);
        chk("no link", s + 1, n_start);
        wr(OFF_LINK_CFG, 32'h1);
        rdc("link", OFF_LINK_CFG, 32'h1, 1'b0);
        pulse(8'h01);
        repeat (2) @(negedge ref_clk_i);
        chk("link start", s + 2, n_start);
        chk("link busy", 32'h1, {31'h0, busy});
        wr(OFF_ENABLE, 32'h0);
        chk("unit off", 32'h0, {31'h0, unit_on});
        @(negedge ref_clk_i); // the abort lands one edge after the write
        chk("busy off", 32'h0, {31'h0, busy});
        wr(OFF_ENABLE, 32'h1); // odd values are stored but keep it off
        rdc("enable odd", OFF_ENABLE, 32'h1, 1'b0);
        chk("unit odd", 32'h0, {31'h0, unit_on});
        wr(OFF_ENABLE, 32'h0);
        wr(OFF_LINK_CFG, 32'h0);
        pulse(8'h38);
        $display("test cipher task done");
    endtask
    task automatic t_mic();
        for (int i = 1; i >= 0; i--) begin
            @(posedge ref_clk_i);
            mic_pass <= i[0];
            pulse(8'h40);
            rdc("mic", OFF_MIC, i, 1'b0);
        end
        $display("test integrity result done");
    endtask
    initial begin
        repeat (3) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        t_reset();
        t_irq_en();
        t_irq();
        t_task();
        t_mic();
        report_and_stop();
    end
endmodule // tb
